// ==== design/biop_pkg.sv ====
/*
 * Package for the bidirectional I/O port bank: register indices, per-variant
 * implemented-bit masks, reset values and the packed carriers.
 * Assumes a data-memory style register access from the core, one byte wide.
 */
package biop_pkg;

    localparam int NUM_PORTS = 6;

    // Register indices within the bank (data memory offsets, bank-relative)
    localparam logic [4:0] REG_A_DATA = 5'h00;
    localparam logic [4:0] REG_A_DIR  = 5'h01;
    localparam logic [4:0] REG_A_PU   = 5'h02;
    localparam logic [4:0] REG_A_WAKE = 5'h03;
    localparam logic [4:0] REG_B_DATA = 5'h04;
    localparam logic [4:0] REG_B_DIR  = 5'h05;
    localparam logic [4:0] REG_B_PU   = 5'h06;
    localparam logic [4:0] REG_C_DATA = 5'h07;
    localparam logic [4:0] REG_C_DIR  = 5'h08;
    localparam logic [4:0] REG_C_PU   = 5'h09;
    localparam logic [4:0] REG_D_DATA = 5'h0a;
    localparam logic [4:0] REG_D_DIR  = 5'h0b;
    localparam logic [4:0] REG_D_PU   = 5'h0c;
    localparam logic [4:0] REG_E_DATA = 5'h0d;
    localparam logic [4:0] REG_E_DIR  = 5'h0e;
    localparam logic [4:0] REG_E_PU   = 5'h0f;
    localparam logic [4:0] REG_F_DATA = 5'h10;
    localparam logic [4:0] REG_F_DIR  = 5'h11;
    localparam logic [4:0] REG_F_PU   = 5'h12;

    // Reset values
    localparam logic [7:0] RST_DATA = 8'hff;
    localparam logic [7:0] RST_DIR  = 8'hff;
    localparam logic [7:0] RST_PU   = 8'h00;
    localparam logic [7:0] RST_WAKE = 8'h00;

    // Variant: 0 smallest, 1 middle, 2 largest
    localparam logic [1:0] VAR_SMALL  = 2'h0;
    localparam logic [1:0] VAR_MIDDLE = 2'h1;
    localparam logic [1:0] VAR_LARGE  = 2'h2;

    // Implemented-bit masks per variant, ports A..F at index 0..5
    typedef logic [NUM_PORTS-1:0][7:0] biop_masks_t;
    localparam biop_masks_t MASK_SMALL =
        {8'h00, 8'h3f, 8'h00, 8'h0f, 8'hff, 8'hff};
    localparam biop_masks_t MASK_MIDDLE =
        {8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    localparam biop_masks_t MASK_LARGE =
        {8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

    // Register access from the core
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [4:0] addr;
        logic [7:0] wrData;
    } biop_req_t;

    // One port's pin controls
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oeN;
        logic [7:0] pullEn;
    } biop_pin_t;

    // Register kinds within a port
    typedef enum logic [1:0] {
        KIND_DATA = 2'b00,
        KIND_DIR  = 2'b01,
        KIND_PU   = 2'b10,
        KIND_WAKE = 2'b11
    } biop_kind_t;

endpackage

// ==== design/biop_port.sv ====
/*
 * One 8-bit port: output latch, direction and pull-high registers, pin
 * drive and read-back mux. Assumes the parent decodes address to a port.
 */
`timescale 1ns/1ps
module biop_port (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 holdRst,
    input  wire logic [7:0]           implMask,
    input  wire logic                 wrEn,
    input  wire biop_pkg::biop_kind_t kind,
    input  wire logic [7:0]           wrData,
    input  wire logic [7:0]           pinIn,
    input  wire logic [7:0]           nmosMode,
    output logic      [7:0]           dataRd,
    output logic      [7:0]           dirRd,
    output logic      [7:0]           puRd,
    output biop_pkg::biop_pin_t       pin
);

    logic [7:0] data_r;
    logic [7:0] data_nxt;
    logic [7:0] dir_r;
    logic [7:0] dir_nxt;
    logic [7:0] pu_r;
    logic [7:0] pu_nxt;

    always_comb begin
        data_nxt = data_r;
        dir_nxt  = dir_r;
        pu_nxt   = pu_r;
        if (wrEn) begin
            unique case (kind)
                // Latch updates even for input pins; drives once output
                biop_pkg::KIND_DATA: data_nxt = wrData & implMask;
                biop_pkg::KIND_DIR:  dir_nxt  = wrData & implMask;
                biop_pkg::KIND_PU:   pu_nxt   = wrData & implMask;
                biop_pkg::KIND_WAKE: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst && !holdRst) begin
            data_r <= biop_pkg::RST_DATA & implMask;
            dir_r  <= biop_pkg::RST_DIR & implMask;
            pu_r   <= biop_pkg::RST_PU;
        end else if (!rst) begin
            data_r <= data_nxt;
            dir_r  <= dir_nxt;
            pu_r   <= pu_nxt;
        end
    end

    always_comb begin
        // Output reads latch, input reads live pin sampled this cycle
        dataRd = ((dir_r & pinIn) | (~dir_r & data_r)) & implMask;
        dirRd  = dir_r & implMask;
        puRd   = pu_r & implMask;
        pin.out    = data_r & implMask;
        pin.oeN    = dir_r | ~implMask;
        pin.pullEn = pu_r & implMask & (dir_r | nmosMode);
    end

endmodule // biop_port

// ==== design/biop_bank.sv ====
/*
 * Bidirectional I/O port bank, ports A..F, registers in data memory.
 * Assumes the core presents one byte access per cycle, inputs synchronous.
 */
`timescale 1ns/1ps
module biop_bank (
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         watchdogSleepRst,
    input  wire logic                         lowPower,
    input  wire logic [1:0]                   variant,
    input  wire biop_pkg::biop_req_t          req,
    output logic      [7:0]                   rdData,
    output logic                              rdValid,
    input  wire logic [5:0][7:0]              pinIn,
    input  wire logic [5:0][7:0]              nmosMode,
    output biop_pkg::biop_pin_t [5:0]         pins,
    output logic                              wakeUp
);

    biop_pkg::biop_masks_t masks;
    logic [7:0]            wake_r;
    logic [7:0]            wake_nxt;
    logic [7:0]            portAPrev_r;
    logic [7:0]            portAPrev_nxt;
    logic [7:0]            rd_r;
    logic [7:0]            rd_nxt;
    logic                  rdv_r;
    logic                  rdv_nxt;
    logic [5:0]            portSel;
    biop_pkg::biop_kind_t  kind;
    logic                  hit;
    logic [5:0][7:0]       dataRd;
    logic [5:0][7:0]       dirRd;
    logic [5:0][7:0]       puRd;

    // Decode an address into port index and register kind
    function automatic void decode(input  logic [4:0]           a,
                                   output logic [5:0]           sel,
                                   output biop_pkg::biop_kind_t k,
                                   output logic                 h);
        sel = 6'h00;
        h   = 1'b1;
        // Port select first, register kind second
        unique case (a)
            biop_pkg::REG_A_DATA,
            biop_pkg::REG_A_DIR,
            biop_pkg::REG_A_PU,
            biop_pkg::REG_A_WAKE: sel = 6'h01;
            biop_pkg::REG_B_DATA,
            biop_pkg::REG_B_DIR,
            biop_pkg::REG_B_PU:   sel = 6'h02;
            biop_pkg::REG_C_DATA,
            biop_pkg::REG_C_DIR,
            biop_pkg::REG_C_PU:   sel = 6'h04;
            biop_pkg::REG_D_DATA,
            biop_pkg::REG_D_DIR,
            biop_pkg::REG_D_PU:   sel = 6'h08;
            biop_pkg::REG_E_DATA,
            biop_pkg::REG_E_DIR,
            biop_pkg::REG_E_PU:   sel = 6'h10;
            biop_pkg::REG_F_DATA,
            biop_pkg::REG_F_DIR,
            biop_pkg::REG_F_PU:   sel = 6'h20;
            default:              h   = 1'b0;
        endcase
        unique case (a)
            biop_pkg::REG_A_DIR,
            biop_pkg::REG_B_DIR,
            biop_pkg::REG_C_DIR,
            biop_pkg::REG_D_DIR,
            biop_pkg::REG_E_DIR,
            biop_pkg::REG_F_DIR:  k = biop_pkg::KIND_DIR;
            biop_pkg::REG_A_PU,
            biop_pkg::REG_B_PU,
            biop_pkg::REG_C_PU,
            biop_pkg::REG_D_PU,
            biop_pkg::REG_E_PU,
            biop_pkg::REG_F_PU:   k = biop_pkg::KIND_PU;
            biop_pkg::REG_A_WAKE: k = biop_pkg::KIND_WAKE;
            default:              k = biop_pkg::KIND_DATA;
        endcase
    endfunction

    always_comb begin
        unique case (variant)
            biop_pkg::VAR_SMALL:  masks = biop_pkg::MASK_SMALL;
            biop_pkg::VAR_MIDDLE: masks = biop_pkg::MASK_MIDDLE;
            biop_pkg::VAR_LARGE:  masks = biop_pkg::MASK_LARGE;
            default:              masks = biop_pkg::MASK_LARGE;
        endcase
    end

    always_comb begin
        decode(req.addr, portSel, kind, hit);
    end

    for (genvar p = 0; p < biop_pkg::NUM_PORTS; p++) begin : g_port
        biop_port u_port (
            .clk_sys  (clk_sys),
            .rst      (rst),
            .holdRst  (watchdogSleepRst),
            .implMask (masks[p]),
            .wrEn     (req.wrEn && hit && portSel[p]),
            .kind     (kind),
            .wrData   (req.wrData),
            .pinIn    (pinIn[p]),
            .nmosMode (nmosMode[p]),
            .dataRd   (dataRd[p]),
            .dirRd    (dirRd[p]),
            .puRd     (puRd[p]),
            .pin      (pins[p])
        );
    end

    always_comb begin
        wake_nxt   = wake_r;
        portAPrev_nxt = pinIn[0];
        rd_nxt     = rd_r;
        rdv_nxt    = 1'b0;
        if (req.wrEn && hit && portSel[0] && kind == biop_pkg::KIND_WAKE) begin
            wake_nxt = req.wrData;
        end
        if (req.rdEn) begin
            // Unmapped addresses read as zero
            rdv_nxt = 1'b1;
            rd_nxt  = 8'h00;
            for (int p = 0; p < biop_pkg::NUM_PORTS; p++) begin
                if (hit && portSel[p]) begin
                    unique case (kind)
                        biop_pkg::KIND_DATA: rd_nxt = dataRd[p];
                        biop_pkg::KIND_DIR:  rd_nxt = dirRd[p];
                        biop_pkg::KIND_PU:   rd_nxt = puRd[p];
                        biop_pkg::KIND_WAKE: rd_nxt = wake_r;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst && !watchdogSleepRst) begin
            wake_r      <= biop_pkg::RST_WAKE;
            portAPrev_r <= 8'hff;
            rd_r        <= 8'h00;
            rdv_r       <= 1'b0;
        end else if (rst) begin
            portAPrev_r <= pinIn[0];
            rdv_r       <= 1'b0;
        end else begin
            wake_r      <= wake_nxt;
            portAPrev_r <= portAPrev_nxt;
            rd_r        <= rd_nxt;
            rdv_r       <= rdv_nxt;
        end
    end

    always_comb begin
        rdData  = rd_r;
        rdValid = rdv_r;
        // Falling edge on an enabled port A input while powered down
        // Output pins never wake, whatever their wake-up bit says
        wakeUp  = lowPower && |(portAPrev_r & ~pinIn[0] & wake_r
                                & pins[0].oeN);
    end

endmodule // biop_bank

// ==== testbench/biop_pin_model.sv ====
/* Behavioural model of the circuitry on the port pins.
   Assumes the bench picks, per pin, a strong outside drive or release. */
`timescale 1ns/1ps
module biop_pin_model (
    input  wire biop_pkg::biop_pin_t [5:0] pins,
    input  wire logic [5:0][7:0]           extDrive,
    input  wire logic [5:0][7:0]           extEn,
    output logic      [5:0][7:0]           pinLevel
);
    // Outside drive wins, so a read can tell the latch from the pin
    always_comb begin
        for (int p = 0; p < 6; p++) begin
            pinLevel[p] = (extEn[p] & extDrive[p])
                | (~extEn[p] & ~pins[p].oeN & pins[p].out)
                | (~extEn[p] & pins[p].oeN
                   & (pins[p].pullEn | ~extDrive[p]));
        end
    end
endmodule // biop_pin_model

// ==== testbench/biop_monitor.sv ====
/* Port-level checker for the I/O port bank.
   Assumes a bind onto biop_bank; watches its ports only. */
`timescale 1ns/1ps
module biop_monitor (
    input wire logic                      clk_sys,
    input wire logic                      rst,
    input wire logic                      watchdogSleepRst,
    input wire logic                      lowPower,
    input wire logic [1:0]                variant,
    input wire biop_pkg::biop_req_t       req,
    input wire logic [7:0]                rdData,
    input wire logic                      rdValid,
    input wire logic [5:0][7:0]           pinIn,
    input wire logic [5:0][7:0]           nmosMode,
    input wire biop_pkg::biop_pin_t [5:0] pins,
    input wire logic                      wakeUp
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [5:0]                pullBad;
    biop_pkg::biop_pin_t [5:0] snap_r;
    always_comb begin
        for (int p = 0; p < 6; p++) begin
            pullBad[p] = |(pins[p].pullEn & ~pins[p].oeN & ~nmosMode[p]);
        end
    end
    // Held through reset, so a kept reset can be compared afterwards
    always_ff @(posedge clk_sys) begin
        if (!rst) begin
            snap_r <= pins;
        end
    end
    sequence s_port_a_wr;
        req.wrEn && req.addr == biop_pkg::REG_A_DATA;
    endsequence
    sequence s_port_a_dir;
        req.wrEn && req.addr == biop_pkg::REG_A_DIR;
    endsequence
    a_read_valid: assert property (req.rdEn |=> rdValid)
        else $error("read not answered");
    a_valid_pulse: assert property (!req.rdEn |=> !rdValid)
        else $error("read valid without read");
    a_unmapped_zero: assert property (req.rdEn
        && req.addr > biop_pkg::REG_F_PU |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    a_pull_gated: assert property (pullBad == 6'h00)
        else $error("pull-high on push-pull output");
    a_latch_holds: assert property (!req.wrEn |=>
        $stable({pins[0].out, pins[1].out, pins[2].out}))
        else $error("latch changed without write");
    a_port_a_write: assert property (s_port_a_wr |=>
        pins[0].out == $past(req.wrData))
        else $error("latch not loaded");
    a_dir_write: assert property (s_port_a_dir |=>
        pins[0].oeN == $past(req.wrData))
        else $error("direction not applied");
    a_reset_input: assert property ($fell(rst)
        && !$past(watchdogSleepRst)
        |-> pins[0].oeN == 8'hff && pins[1].pullEn == 8'h00)
        else $error("reset did not make inputs");
    a_sleep_keep: assert property ($fell(rst)
        && $past(watchdogSleepRst)
        |-> pins == snap_r)
        else $error("sleep reset lost state");
    a_wake_edge: assert property (wakeUp |-> lowPower
        && ($past(pinIn[0]) & ~pinIn[0] & pins[0].oeN) != 8'h00)
        else $error("wake without falling input");
endmodule // biop_monitor
bind biop_bank biop_monitor u_mon (.clk_sys, .rst, .watchdogSleepRst,
    .lowPower, .variant, .req, .rdData, .rdValid, .pinIn, .nmosMode,
    .pins, .wakeUp);

// ==== testbench/testbench.sv ====
/* Self-checking bench for the I/O port bank.
   Assumes the pin model stands for all outside circuitry. */
`timescale 1ns/1ps
module testbench;
    logic                      clk_sys = 1'b0;
    logic                      rst = 1'b1;
    logic                      watchdogSleepRst = 1'b0;
    logic                      lowPower = 1'b0;
    logic [1:0]                variant = biop_pkg::VAR_LARGE;
    biop_pkg::biop_req_t       req = '0;
    logic [7:0]                rdData;
    logic                      rdValid;
    logic                      wakeUp;
    logic [5:0][7:0]           pinIn;
    logic [5:0][7:0]           nmosMode = '0;
    logic [5:0][7:0]           extDrive = '1;
    logic [5:0][7:0]           extEn = '1;
    biop_pkg::biop_pin_t [5:0] pins;
    int                        err_count = 0;
    int                        n_checks = 0;
    int                        cyc = 0;
    biop_bank dut (.clk_sys, .rst, .watchdogSleepRst, .lowPower, .variant,
        .req, .rdData, .rdValid, .pinIn, .nmosMode, .pins, .wakeUp);
    biop_pin_model u_ext (.pins, .extDrive, .extEn, .pinLevel(pinIn));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 2000) begin
            err_count++;
            report_and_stop();
        end
    end
    task chk(string nm, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [4:0] ra(int p, int k);
        return (p == 0) ? 5'(k) : 5'(4 + 3 * (p - 1) + k);
    endfunction
    // Request stays up until the caller lowers it, so back to back is safe
    task wr(logic [4:0] a, logic [7:0] d);
        req = '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        #1;
    endtask
    task rc(logic [4:0] a, logic [7:0] e);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        #1;
        chk("rdValid", 8'h01, {7'h00, rdValid});
        chk("rdData", e, rdData);
    endtask
    task do_rst(logic s, logic [1:0] v);
        req = '0;
        @(posedge clk_sys);
        #1;
        rst = 1'b1;
        watchdogSleepRst = s;
        variant = v;
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        watchdogSleepRst = 1'b0;
    endtask
    task t_reset;
        for (int p = 0; p < 6; p++) begin
            rc(ra(p, 0), biop_pkg::MASK_LARGE[p]);
            rc(ra(p, 1), biop_pkg::MASK_LARGE[p]);
            rc(ra(p, 2), 8'h00);
        end
        rc(biop_pkg::REG_A_WAKE, 8'h00);
        rc(5'h1f, 8'h00);
    endtask
    task t_output;
        extEn[1] = 8'h00;
        wr(biop_pkg::REG_B_DIR, 8'h00);
        wr(biop_pkg::REG_B_DATA, 8'ha5);
        req = '0;
        chk("oeN", 8'h00, pins[1].oeN);
        chk("pin", 8'ha5, pinIn[1]);
        extEn[1] = 8'hff;
        extDrive[1] = 8'h5a;
        rc(biop_pkg::REG_B_DATA, 8'ha5);
        req = '0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("out", 8'ha5, pins[1].out);
    endtask
    task t_input;
        extDrive[2] = 8'h81;
        wr(biop_pkg::REG_C_DATA, 8'h3c);
        rc(biop_pkg::REG_C_DATA, 8'h81);
        extDrive[2] = 8'h7e;
        rc(biop_pkg::REG_C_DATA, 8'h7e);
        extEn[2] = 8'h00;
        wr(biop_pkg::REG_C_DIR, 8'h00);
        req = '0;
        chk("out", 8'h3c, pins[2].out);
        chk("pin", 8'h3c, pinIn[2]);
    endtask
    task t_pull;
        extEn[3] = 8'h00;
        wr(biop_pkg::REG_D_PU, 8'hff);
        rc(biop_pkg::REG_D_PU, 8'hff);
        rc(biop_pkg::REG_D_DATA, 8'hff);
        wr(biop_pkg::REG_D_DIR, 8'h0f);
        req = '0;
        chk("pullEn", 8'h0f, pins[3].pullEn);
        nmosMode[3] = 8'hf0;
        @(posedge clk_sys);
        #1;
        chk("pullEn", 8'hff, pins[3].pullEn);
        wr(biop_pkg::REG_D_PU, 8'h00);
        rc(biop_pkg::REG_D_DATA, 8'hf0);
    endtask
    task t_sleep;
        do_rst(1'b1, biop_pkg::VAR_LARGE);
        rc(biop_pkg::REG_B_DATA, 8'ha5);
        rc(biop_pkg::REG_B_DIR, 8'h00);
        do_rst(1'b0, biop_pkg::VAR_LARGE);
        rc(biop_pkg::REG_B_DIR, 8'hff);
    endtask
    task t_mask;
        do_rst(1'b0, biop_pkg::VAR_SMALL);
        for (int p = 0; p < 6; p++) begin
            rc(ra(p, 1), biop_pkg::MASK_SMALL[p]);
            wr(ra(p, 2), 8'hff);
            rc(ra(p, 2), biop_pkg::MASK_SMALL[p]);
        end
    endtask
    task t_wake;
        wr(biop_pkg::REG_A_WAKE, 8'h01);
        req = '0;
        lowPower = 1'b1;
        @(posedge clk_sys);
        #1;
        extDrive[0] = 8'hfe;
        #1;
        chk("wakeUp", 8'h01, {7'h00, wakeUp});
        @(posedge clk_sys);
        #1;
        extDrive[0] = 8'hfc;
        #1;
        chk("wakeUp", 8'h00, {7'h00, wakeUp});
        // An enabled pin turned output must not wake on a fall
        @(posedge clk_sys);
        #1;
        extDrive[0] = 8'hff;
        wr(biop_pkg::REG_A_DATA, 8'h5a);
        wr(biop_pkg::REG_A_DIR, 8'hfe);
        req = '0;
        extDrive[0] = 8'hfe;
        #1;
        chk("wakeUp", 8'h00, {7'h00, wakeUp});
        lowPower = 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_reset();
        t_output();
        t_input();
        t_pull();
        t_sleep();
        t_mask();
        t_wake();
        report_and_stop();
    end
endmodule // testbench
